// file: core/csp_core_regs.sv
// core status, stack, data pointer and power control registers
`timescale 1ns/1ps
`include "csp_consts.svh"

module csp_core_regs (
  // clock and reset
  input  wire logic                  clk_sys_in,
  input  wire logic                  reset_in,
  input  wire logic                  por_in,
  input  wire logic                  wdt_overflow_in,
  // direct special function register bus
  input  wire csp_pkg::csp_sfr_req_t sfr_req_in,
  output logic [7:0]                 sfr_rdata_out,
  output logic                       sfr_hit_out,
  // datapath flags and stack pushes and pops
  input  wire csp_pkg::csp_flag_upd_t flag_upd_in,
  input  wire logic [7:0]            acc_in,
  input  wire logic                  push_in,
  input  wire logic                  pop_in,
  input  wire logic                  call_push_in,
  input  wire logic [15:0]           ret_addr_in,
  // internal data memory address decode
  input  wire logic [7:0]            mem_addr_in,
  input  wire logic                  mem_indirect_in,
  input  wire logic [2:0]            reg_index_in,
  output logic [7:0]                 reg_ram_addr_out,
  output logic                       ram_sel_out,
  output logic                       sfr_sel_out,
  output logic                       bit_addr_ok_out,
  // stack write port
  output logic                       stack_we_out,
  output logic [7:0]                 stack_addr_out,
  output logic [7:0]                 stack_wdata_out,
  // wake and fetch status
  input  wire logic                  irq_pending_in,
  input  wire logic                  int_fetch_in,
  // clock gating and pins
  output logic                       cpu_clk_en_out,
  output logic                       periph_clk_en_out,
  output logic                       osc_en_out,
  output logic                       ale_out,
  output logic                       baud_double_out,
  output logic [15:0]                data_pointer_out,
  output logic [1:0]                 bank_select_out
);

  csp_pkg::csp_state_t state_r;
  csp_pkg::csp_state_t state_nxt;

  // bank base address from the two select bits
  function automatic logic [7:0] bank_base(input logic [1:0] sel);
    bank_base = {3'h0, sel, 3'h0};
  endfunction

  // odd parity of a byte
  function automatic logic odd_parity(input logic [7:0] v);
    odd_parity = ^v;
  endfunction

  logic       wr_hit;
  logic [7:0] sp_inc;
  logic       second_byte_r;
  logic       second_byte_nxt;
  logic [7:0] ret_high_r;

  assign sp_inc  = state_r.sp + `CSP_ONE8;
  assign wr_hit  = sfr_req_in.wr;

  // next state of the whole bank
  always_comb begin
    state_nxt = state_r;
    second_byte_nxt = 1'b0;
    // sfr writes, direct access only
    if (wr_hit) begin
      unique case (sfr_req_in.addr)
        `CSP_ADDR_SP: state_nxt.sp = sfr_req_in.wdata;
        `CSP_ADDR_DPL: state_nxt.data_pointer[7:0] = sfr_req_in.wdata;
        `CSP_ADDR_DPH: state_nxt.data_pointer[15:8] = sfr_req_in.wdata;
        `CSP_ADDR_POWER_CONTROL: begin
          state_nxt.power_control = sfr_req_in.wdata & `CSP_POWER_CONTROL_WMASK;
        end
        `CSP_ADDR_SYSTEM_CONTROL: begin
          state_nxt.addr_latch_output_inhibit = sfr_req_in.wdata[`CSP_SYS_ADDR_LATCH_OUTPUT_INHIBIT];
          if (!sfr_req_in.wdata[`CSP_SYS_WDR]) begin
            state_nxt.watchdog_reset_flag = 1'b0;
          end
        end
        `CSP_ADDR_PSW: begin
          state_nxt.program_status_word = sfr_req_in.wdata & `CSP_PSW_WMASK;
        end
        default: ;
      endcase
    end
    // datapath flag updates win over a same-cycle write
    if (flag_upd_in.carry_we) begin
      state_nxt.program_status_word[`CSP_PSW_CY] = flag_upd_in.carry;
    end
    if (flag_upd_in.aux_we) begin
      state_nxt.program_status_word[`CSP_PSW_AC] = flag_upd_in.aux_carry;
    end
    if (flag_upd_in.ovf_we) begin
      state_nxt.program_status_word[`CSP_PSW_OV] = flag_upd_in.ovf;
    end
    state_nxt.program_status_word[1] = 1'b0;
    state_nxt.program_status_word[`CSP_PSW_P] = odd_parity(acc_in);
    // stack: pre-increment, return address low byte then high byte
    if (second_byte_r) begin
      state_nxt.sp = sp_inc;
    end else if (call_push_in) begin
      state_nxt.sp = sp_inc;
      second_byte_nxt = 1'b1;
    end else if (push_in) begin
      state_nxt.sp = sp_inc;
    end else if (pop_in) begin
      state_nxt.sp = state_r.sp - `CSP_ONE8;
    end
    // power modes; power-down only ends on reset
    unique case (state_r.mode)
      csp_pkg::CSP_RUN: begin
        if (state_nxt.power_control[`CSP_POWER_CONTROL_PD]) begin
          state_nxt.mode = csp_pkg::CSP_POWER_DOWN_REQUEST;
        end else if (state_nxt.power_control[`CSP_POWER_CONTROL_IDLE]) begin
          state_nxt.mode = csp_pkg::CSP_IDLE;
        end
      end
      csp_pkg::CSP_IDLE: begin
        if (irq_pending_in) begin
          state_nxt.mode = csp_pkg::CSP_RUN;
          state_nxt.power_control[`CSP_POWER_CONTROL_IDLE] = 1'b0;
        end
      end
      csp_pkg::CSP_POWER_DOWN_REQUEST: state_nxt.mode = csp_pkg::CSP_POWER_DOWN_REQUEST;
      default: state_nxt.mode = csp_pkg::CSP_RUN;
    endcase
    // address strobe at fosc/6; frozen in power-down, gated by the
    // next mode so no strobe leaks out in the first power-down cycle
    if (state_nxt.mode != csp_pkg::CSP_POWER_DOWN_REQUEST) begin
      if (state_r.ale_cnt == `CSP_ALE_DIV) begin
        state_nxt.ale_cnt = 3'h0;
      end else begin
        state_nxt.ale_cnt = state_r.ale_cnt + `CSP_ONE3;
      end
      state_nxt.ale = (state_r.ale_cnt == 3'h0) &&
                      !(state_r.addr_latch_output_inhibit && int_fetch_in);
    end else begin
      state_nxt.ale = 1'b0;
    end
    // registered read data
    unique case (sfr_req_in.addr)
      `CSP_ADDR_SP: state_nxt.rdata = state_r.sp;
      `CSP_ADDR_DPL: state_nxt.rdata = state_r.data_pointer[7:0];
      `CSP_ADDR_DPH: state_nxt.rdata = state_r.data_pointer[15:8];
      `CSP_ADDR_POWER_CONTROL: state_nxt.rdata = state_r.power_control;
      `CSP_ADDR_SYSTEM_CONTROL: state_nxt.rdata = {state_r.watchdog_reset_flag, 6'h00, state_r.addr_latch_output_inhibit};
      `CSP_ADDR_PSW: state_nxt.rdata = state_r.program_status_word;
      default: state_nxt.rdata = `CSP_ZERO8;
    endcase
    if (!sfr_req_in.rd) begin
      state_nxt.rdata = `CSP_ZERO8;
    end
  end

  // registers; the watchdog flag outlives its own reset
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state_r.sp      <= `CSP_SP_RESET;
      state_r.data_pointer    <= `CSP_ZERO16;
      state_r.program_status_word     <= `CSP_ZERO8;
      state_r.power_control    <= `CSP_ZERO8;
      state_r.addr_latch_output_inhibit    <= 1'b0;
      state_r.mode    <= csp_pkg::CSP_RUN;
      state_r.ale_cnt <= 3'h0;
      state_r.ale     <= 1'b0;
      state_r.rdata   <= `CSP_ZERO8;
      second_byte_r   <= 1'b0;
      ret_high_r      <= `CSP_ZERO8;
      if (por_in) begin
        state_r.watchdog_reset_flag <= 1'b0;
      end else if (wdt_overflow_in) begin
        state_r.watchdog_reset_flag <= 1'b1;
      end
    end else begin
      state_r       <= state_nxt;
      second_byte_r <= second_byte_nxt;
      if (call_push_in) begin
        ret_high_r <= ret_addr_in[15:8];
      end
      if (wdt_overflow_in) begin
        state_r.watchdog_reset_flag <= 1'b1;
      end
    end
  end

  // stack write: low byte at sp+1, then high byte at sp+2
  always_comb begin
    stack_we_out    = call_push_in || second_byte_r || push_in;
    stack_addr_out  = sp_inc;
    stack_wdata_out = second_byte_r ? ret_high_r : ret_addr_in[7:0];
  end

  // memory space decode; direct upper half goes to registers
  always_comb begin
    reg_ram_addr_out = bank_base(state_r.program_status_word[`CSP_PSW_RS1:`CSP_PSW_RS0])
                       | {5'h00, reg_index_in};
    sfr_sel_out = !mem_indirect_in &&
                  (mem_addr_in >= `CSP_RAM_UPPER);
    ram_sel_out = !sfr_sel_out;
    bit_addr_ok_out = (mem_addr_in >= `CSP_BITRAM_LO) &&
                      (mem_addr_in <= `CSP_BITRAM_HI);
  end

  // outputs
  assign sfr_rdata_out     = state_r.rdata;
  assign sfr_hit_out       = (sfr_req_in.addr == `CSP_ADDR_SP) ||
                             (sfr_req_in.addr == `CSP_ADDR_DPL) ||
                             (sfr_req_in.addr == `CSP_ADDR_DPH) ||
                             (sfr_req_in.addr == `CSP_ADDR_POWER_CONTROL) ||
                             (sfr_req_in.addr == `CSP_ADDR_SYSTEM_CONTROL) ||
                             (sfr_req_in.addr == `CSP_ADDR_PSW);
  assign cpu_clk_en_out    = (state_r.mode == csp_pkg::CSP_RUN);
  assign periph_clk_en_out = (state_r.mode != csp_pkg::CSP_POWER_DOWN_REQUEST);
  assign osc_en_out        = (state_r.mode != csp_pkg::CSP_POWER_DOWN_REQUEST);
  assign ale_out           = state_r.ale;
  assign baud_double_out   = state_r.power_control[`CSP_POWER_CONTROL_BAUD_DOUBLER];
  assign data_pointer_out  = state_r.data_pointer;
  assign bank_select_out   = state_r.program_status_word[`CSP_PSW_RS1:`CSP_PSW_RS0];

endmodule

// file: inc/csp_consts.svh
// constants for the core status and power register bank
`ifndef CSP_CONSTS_SVH
`define CSP_CONSTS_SVH
`define CSP_ADDR_SP      8'h81
`define CSP_ADDR_DPL     8'h82
`define CSP_ADDR_DPH     8'h83
`define CSP_ADDR_POWER_CONTROL    8'h87
`define CSP_ADDR_SYSTEM_CONTROL  8'hBF
`define CSP_ADDR_PSW     8'hD0
`define CSP_SP_RESET     8'h07
`define CSP_ZERO8        8'h00
`define CSP_ZERO16       16'h0000
`define CSP_SYS_WDR      7
`define CSP_SYS_ADDR_LATCH_OUTPUT_INHIBIT     0
`define CSP_PSW_CY       7
`define CSP_PSW_AC       6
`define CSP_PSW_F0       5
`define CSP_PSW_RS1      4
`define CSP_PSW_RS0      3
`define CSP_PSW_OV       2
`define CSP_PSW_P        0
`define CSP_POWER_CONTROL_BAUD_DOUBLER    7
`define CSP_POWER_CONTROL_GF1     3
`define CSP_POWER_CONTROL_GF0     2
`define CSP_POWER_CONTROL_PD      1
`define CSP_POWER_CONTROL_IDLE    0
`define CSP_PSW_WMASK    8'hFC
`define CSP_POWER_CONTROL_WMASK   8'h8F
`define CSP_RAM_UPPER    8'h80
`define CSP_BITRAM_LO    8'h20
`define CSP_BITRAM_HI    8'h2F
`define CSP_ALE_DIV      3'h5
`define CSP_ONE8         8'h01
`define CSP_ONE3         3'h1
`endif

// file: inc/csp_pkg.sv
// types shared by the core status and power register bank
package csp_pkg;
  typedef enum logic [1:0] {
    CSP_RUN,
    CSP_IDLE,
    CSP_POWER_DOWN_REQUEST
  } csp_mode_t;

  // one special function register bus request
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } csp_sfr_req_t;

  // arithmetic flag update from the core datapath
  typedef struct packed {
    logic carry_we;
    logic carry;
    logic aux_we;
    logic aux_carry;
    logic ovf_we;
    logic ovf;
  } csp_flag_upd_t;

  // state of the bank apart from second_byte_r and ret_high_r
  typedef struct packed {
    logic [7:0]  sp;
    logic [15:0] data_pointer;
    logic [7:0]  program_status_word;
    logic [7:0]  power_control;
    logic        watchdog_reset_flag;
    logic        addr_latch_output_inhibit;
    csp_mode_t   mode;
    logic [2:0]  ale_cnt;
    logic        ale;
    logic [7:0]  rdata;
  } csp_state_t;
endpackage

// file: verification/csp_core_regs_chk.sv
// assertion checker for the core status and power register bank
`timescale 1ns/1ps
module csp_core_regs_chk (
  // clock and reset
  input wire logic                  clk_sys_in,
  input wire logic                  reset_in,
  // register bus
  input wire csp_pkg::csp_sfr_req_t sfr_req_in,
  input wire logic [7:0]            sfr_rdata_out,
  input wire logic                  sfr_hit_out,
  // stack and decode
  input wire logic                  call_push_in,
  input wire logic [15:0]           ret_addr_in,
  input wire logic [7:0]            mem_addr_in,
  input wire logic                  mem_indirect_in,
  input wire logic [2:0]            reg_index_in,
  input wire logic [7:0]            reg_ram_addr_out,
  input wire logic                  ram_sel_out,
  input wire logic                  sfr_sel_out,
  input wire logic                  bit_addr_ok_out,
  input wire logic                  stack_we_out,
  input wire logic [7:0]            stack_addr_out,
  input wire logic [7:0]            stack_wdata_out,
  // power and pins
  input wire logic                  irq_pending_in,
  input wire logic                  cpu_clk_en_out,
  input wire logic                  periph_clk_en_out,
  input wire logic                  osc_en_out,
  input wire logic                  ale_out,
  input wire logic                  baud_double_out,
  input wire logic [1:0]            bank_select_out
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  a_call_two_bytes: assert property (call_push_in |->
    stack_we_out && stack_wdata_out == ret_addr_in[7:0] ##1 stack_we_out
    && stack_addr_out == $past(stack_addr_out) + 8'h01
    && stack_wdata_out == $past(ret_addr_in[15:8]))
    else $error("call push bytes wrong");
  a_power_down_request_hold: assert property (!osc_en_out |=> !osc_en_out)
    else $error("left power-down without reset");
  a_power_down_request_all_off: assert property (!osc_en_out |->
    !cpu_clk_en_out && !periph_clk_en_out && !ale_out)
    else $error("clock alive in power-down");
  a_idle_periph: assert property (!cpu_clk_en_out && osc_en_out
    |-> periph_clk_en_out) else $error("peripherals stopped in idle");
  a_idle_wake: assert property (!cpu_clk_en_out && osc_en_out
    && irq_pending_in |-> ##[1:2] cpu_clk_en_out)
    else $error("interrupt did not wake idle");
  a_bank_write: assert property (sfr_req_in.wr
    && sfr_req_in.addr == 8'hD0
    |=> bank_select_out == $past(sfr_req_in.wdata[4:3]))
    else $error("bank select not written");
  a_baud_write: assert property (sfr_req_in.wr
    && sfr_req_in.addr == 8'h87
    |=> baud_double_out == $past(sfr_req_in.wdata[7]))
    else $error("baud doubler not written");
  a_unmapped_zero: assert property (sfr_req_in.rd
    && !sfr_hit_out |=> sfr_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  a_ale_gap_five: assert property (ale_out |=> !ale_out [*5])
    else $error("strobe closer than six cycles");
  a_bank_map: assert property (reg_ram_addr_out ==
    {3'h0, bank_select_out, reg_index_in}) else $error("bank map wrong");
  a_addr_space: assert property (
    sfr_sel_out == (mem_addr_in[7] && !mem_indirect_in)
    && ram_sel_out == (!mem_addr_in[7] || mem_indirect_in))
    else $error("address space select wrong");
  a_bit_window: assert property (bit_addr_ok_out ==
    (mem_addr_in >= 8'h20 && mem_addr_in <= 8'h2F))
    else $error("bit window wrong");

  // main scenarios reached
  c_call: cover property (call_push_in);
  c_idle: cover property (!cpu_clk_en_out && osc_en_out);
  c_power_down_request: cover property (!osc_en_out);
endmodule

bind csp_core_regs csp_core_regs_chk i_csp_core_regs_chk (
  .clk_sys_in, .reset_in, .sfr_req_in, .sfr_rdata_out, .sfr_hit_out,
  .call_push_in, .ret_addr_in, .mem_addr_in, .mem_indirect_in,
  .reg_index_in, .reg_ram_addr_out, .ram_sel_out, .sfr_sel_out,
  .bit_addr_ok_out, .stack_we_out, .stack_addr_out, .stack_wdata_out,
  .irq_pending_in, .cpu_clk_en_out, .periph_clk_en_out, .osc_en_out,
  .ale_out, .baud_double_out, .bank_select_out);

// file: verification/csp_core_regs_tb.sv
// self-checking bench for the core status and power register bank
`timescale 1ns/1ps
module csp_core_regs_tb;
  // stimulus
  logic                   clk_sys_in = 1'b0;
  logic                   reset_in = 1'b1;
  logic                   por = 1'b1;
  logic                   wdt = 1'b0;
  csp_pkg::csp_sfr_req_t  req = '0;
  csp_pkg::csp_flag_upd_t flg = '0;
  logic [7:0]             acc = 8'h00;
  logic                   push = 1'b0;
  logic                   call = 1'b0;
  logic [7:0]             maddr = 8'h00;
  logic                   mind = 1'b0;
  logic                   irq = 1'b0;
  logic                   ifetch = 1'b0;
  // observation
  logic [7:0]  rdata, rram, saddr, swd;
  logic        hit, rsel, ssel, bok, swe, cpu, per, osc, ale, baud;
  logic [15:0] data_pointer;
  logic [1:0]  bank;
  int          err_count = 0;
  int          checks = 0;
  int          n;

  always #4 clk_sys_in = ~clk_sys_in;

  csp_core_regs i_csp_core_regs (.clk_sys_in(clk_sys_in),
    .reset_in(reset_in), .por_in(por), .wdt_overflow_in(wdt),
    .sfr_req_in(req), .sfr_rdata_out(rdata), .sfr_hit_out(hit),
    .flag_upd_in(flg), .acc_in(acc), .push_in(push), .pop_in(1'b0),
    .call_push_in(call), .ret_addr_in(16'h1234), .mem_addr_in(maddr),
    .mem_indirect_in(mind), .reg_index_in(3'h5),
    .reg_ram_addr_out(rram), .ram_sel_out(rsel), .sfr_sel_out(ssel),
    .bit_addr_ok_out(bok), .stack_we_out(swe), .stack_addr_out(saddr),
    .stack_wdata_out(swd), .irq_pending_in(irq), .int_fetch_in(ifetch),
    .cpu_clk_en_out(cpu), .periph_clk_en_out(per), .osc_en_out(osc),
    .ale_out(ale), .baud_double_out(baud), .data_pointer_out(data_pointer),
    .bank_select_out(bank));

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // inputs always move 1 ns after the edge
  task automatic tick(input int c);
    repeat (c) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    tick(1);
    req = '0;
  endtask
  // read data stands for the cycle after the request
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    tick(1);
    req = '0;
    chk(rdata, e);
  endtask
  task automatic dec(input logic [7:0] a, input logic i, input logic [2:0] e);
    maddr = a;
    mind = i;
    tick(1);
    chk({rsel, ssel, bok}, e);
  endtask
  task automatic ale_cnt();
    n = 0;
    repeat (12) begin
      tick(1);
      n += ale;
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // cut a hang well past the ~80 cycles the tests need
  initial begin
    #20000;
    err_count++;
    tally_and_finish();
  end

  initial begin
    tick(5);
    reset_in = 1'b0;
    por = 1'b0;
    rc(8'h81, 8'h07);
    rc(8'h85, 8'h00);
    wr(8'h81, 8'hFF);
    rc(8'h81, 8'hFF);
    wr(8'h82, 8'hA5);
    wr(8'h83, 8'h3C);
    chk(data_pointer, 16'h3CA5);
    rc(8'h83, 8'h3C);
    $display("pointer test done");
    acc = 8'h07;
    wr(8'hD0, 8'hFF);
    rc(8'hD0, 8'hFD);
    for (n = 0; n < 4; n++) begin
      wr(8'hD0, 8'(n * 8));
      chk(rram, 24'(n * 8 + 5));
    end
    acc = 8'h03;
    tick(1);
    rc(8'hD0, 8'h18);
    flg.aux_we = 1'b1;
    flg.aux_carry = 1'b1;
    tick(1);
    flg = '0;
    rc(8'hD0, 8'h58);
    $display("status test done");
    wr(8'h87, 8'hFC);
    rc(8'h87, 8'h8C);
    chk(baud, 1'b1);
    wr(8'h87, 8'h0C);
    chk(baud, 1'b0);
    wr(8'h81, 8'h07);
    call = 1'b1;
    #1;
    chk({swe, saddr, swd}, 24'h010834);
    tick(1);
    call = 1'b0;
    #1;
    chk({swe, saddr, swd}, 24'h010912);
    tick(1);
    rc(8'h81, 8'h09);
    push = 1'b1;
    #1;
    chk(saddr, 8'h0A);
    tick(1);
    push = 1'b0;
    rc(8'h81, 8'h0A);
    dec(8'h2F, 1'b0, 3'b101);
    dec(8'h30, 1'b0, 3'b100);
    dec(8'h7F, 1'b0, 3'b100);
    dec(8'h90, 1'b0, 3'b010);
    dec(8'h90, 1'b1, 3'b100);
    $display("stack test done");
    wr(8'hBF, 8'h01);
    ifetch = 1'b1;
    ale_cnt();
    chk(n, 0);
    ifetch = 1'b0;
    ale_cnt();
    chk(n, 2);
    wdt = 1'b1;
    tick(1);
    wdt = 1'b0;
    rc(8'hBF, 8'h81);
    reset_in = 1'b1;
    tick(1);
    reset_in = 1'b0;
    rc(8'hBF, 8'h80);
    wr(8'hBF, 8'h00);
    rc(8'hBF, 8'h00);
    $display("control test done");
    wr(8'h81, 8'h5A);
    wr(8'h87, 8'h01);
    tick(1);
    chk({cpu, per, osc}, 3'b011);
    irq = 1'b1;
    tick(2);
    irq = 1'b0;
    chk({cpu, per, osc}, 3'b111);
    rc(8'h87, 8'h00);
    rc(8'h81, 8'h5A);
    wr(8'h87, 8'h02);
    tick(1);
    chk({cpu, per, osc}, 3'b000);
    irq = 1'b1;
    tick(3);
    chk(osc, 1'b0);
    irq = 1'b0;
    reset_in = 1'b1;
    tick(1);
    reset_in = 1'b0;
    chk({cpu, per, osc}, 3'b111);
    $display("power test done");
    tally_and_finish();
  end
endmodule
